// >>> hdl/osae_pkg.sv
// Shared constants and types of the operand specifier evaluator.
// Assumes one processor clock; no timing constants are needed.
package osae_pkg;

	localparam logic [3:0] MODE_INDEX = 4'h4;
	localparam logic [3:0] MODE_REG = 4'h5;
	localparam logic [3:0] MODE_REG_DEF = 4'h6;
	localparam logic [3:0] MODE_AUTODEC = 4'h7;
	localparam logic [3:0] MODE_AUTOINC = 4'h8;
	localparam logic [3:0] MODE_AUTOINC_DEF = 4'h9;
	localparam logic [3:0] MODE_BDISP = 4'hA;
	localparam logic [3:0] MODE_BDISP_DEF = 4'hB;
	localparam logic [3:0] MODE_WDISP = 4'hC;
	localparam logic [3:0] MODE_WDISP_DEF = 4'hD;
	localparam logic [3:0] MODE_LDISP = 4'hE;
	localparam logic [3:0] MODE_LDISP_DEF = 4'hF;
	localparam logic [3:0] REG_PC = 4'hF;
	localparam logic [1:0] LIT_TAG = 2'h0;
	localparam int ADDR_W = 32;
	localparam int LIT_W = 128;
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
	localparam logic [7:0] F_BIAS = 8'h80;
	localparam logic [10:0] G_BIAS = 11'h400;
	localparam logic [14:0] H_BIAS = 15'h4000;

	typedef enum logic [3:0] {
		DT_BYTE = 4'h0,
		DT_WORD = 4'h1,
		DT_LONG = 4'h2,
		DT_QUAD = 4'h3,
		DT_OCTA = 4'h4,
		DT_FFLT = 4'h5,
		DT_DFLT = 4'h6,
		DT_GFLT = 4'h7,
		DT_HFLT = 4'h8
	} osae_dtype_t;

	typedef enum logic [2:0] {
		AC_READ = 3'h0,
		AC_MODIFY = 3'h1,
		AC_WRITE = 3'h2,
		AC_ADDR = 3'h3,
		AC_FIELD = 3'h4
	} osae_access_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EVAL = 3'b010,
		ST_MEM = 3'b100
	} osae_state_t;

endpackage

// >>> hdl/osae_lit_expand.sv
// Expands a six-bit short literal into an operand of the given data type.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module osae_lit_expand
	import osae_pkg::*;
(
	input wire logic [5:0] lit_i,
	input wire osae_dtype_t dtype_i,
	output logic [LIT_W-1:0] value_o
);

	logic [2:0] expo;
	logic [2:0] fra;

	assign expo = lit_i[5:3];
	assign fra = lit_i[2:0];

	always_comb begin
		value_o = '0;
		case (dtype_i)
			DT_FFLT, DT_DFLT: begin
				value_o[14:7] = F_BIAS + {5'h00, expo};
				value_o[6:4] = fra;
			end
			DT_GFLT: begin
				value_o[14:4] = G_BIAS + {8'h00, expo};
				value_o[3:1] = fra;
			end
			DT_HFLT: begin
				value_o[14:0] = H_BIAS + {12'h000, expo};
				value_o[31:29] = fra;
			end
			default: begin
				value_o[5:0] = lit_i;
			end
		endcase
	end

endmodule

// >>> hdl/osae_eval.sv
// Operand specifier evaluator: literal, displacement (deferred), index and branch.
// Assumes the register file answers reads in the same cycle and memory
// answers a longword read with mem_ack_i on the processor clock.
`timescale 1ns/1ps
module osae_eval
	import osae_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic branch_i,
	input wire logic branch_word_i,
	input wire logic [7:0] spec_i,
	input wire logic [7:0] base_spec_i,
	input wire logic [31:0] ext_i,
	input wire osae_access_t access_i,
	input wire osae_dtype_t dtype_i,
	input wire logic [31:0] next_pc_i,
	output logic [3:0] base_sel_o,
	input wire logic [31:0] base_data_i,
	output logic [3:0] index_sel_o,
	input wire logic [31:0] index_data_i,
	output logic mem_req_o,
	output logic [31:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_data_i,
	output logic wb_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_data_o,
	output logic busy_o,
	output logic done_o,
	output logic [31:0] addr_o,
	output logic literal_o,
	output logic [LIT_W-1:0] lit_value_o,
	output logic illegal_fault_o,
	output logic reserved_fault_o
);
	function automatic logic [31:0] sign_widen(input logic [31:0] d, input logic [1:0] w);
		case (w)
			2'h0: sign_widen = {{24{d[7]}}, d[7:0]};
			2'h1: sign_widen = {{16{d[15]}}, d[15:0]};
			default: sign_widen = d;
		endcase
	endfunction
	function automatic logic [2:0] size_log2(input osae_dtype_t t);
		case (t)
			DT_BYTE: size_log2 = 3'h0;
			DT_WORD: size_log2 = 3'h1;
			DT_LONG, DT_FFLT: size_log2 = 3'h2;
			DT_QUAD, DT_DFLT, DT_GFLT: size_log2 = 3'h3;
			default: size_log2 = 3'h4;
		endcase
	endfunction
	osae_state_t state_ff, nxt_state;
	logic [7:0] spec_ff, nxt_spec, base_ff, nxt_base;
	logic [31:0] ext_ff, nxt_ext, pc_ff, nxt_pc, idx_off_ff, nxt_idx_off;
	logic [31:0] addr_ff, nxt_addr, maddr_ff, nxt_maddr, wbd_ff, nxt_wbd;
	osae_access_t acc_ff, nxt_acc;
	osae_dtype_t dt_ff, nxt_dt;
	logic br_ff, nxt_br, brw_ff, nxt_brw, done_ff, nxt_done, lit_ff, nxt_lit;
	logic ill_ff, nxt_ill, rsv_ff, nxt_rsv, wb_ff, nxt_wb;
	logic [3:0] wbs_ff, nxt_wbs;
	logic [LIT_W-1:0] litv_ff, nxt_litv, lit_exp;
	logic is_idx, is_lit, ill_now, rsv_now, deferred;
	logic [7:0] eff;
	logic [3:0] mode, rn;
	logic [31:0] rb, size, disp, ea, idx_now;
	logic [1:0] dsel;
	osae_lit_expand u_lit (
		.lit_i(spec_ff[5:0]),
		.dtype_i(dt_ff),
		.value_o(lit_exp)
	);
	assign is_idx = spec_ff[7:4] == MODE_INDEX;
	assign is_lit = spec_ff[7:6] == LIT_TAG;
	assign eff = is_idx ? base_ff : spec_ff;
	assign mode = eff[7:4];
	assign rn = eff[3:0];
	assign base_sel_o = rn;
	assign index_sel_o = spec_ff[3:0];
	assign rb = (rn == REG_PC) ? pc_ff : base_data_i;
	assign size = 32'h0000_0001 << size_log2(dt_ff);
	assign idx_now = is_idx ? (index_data_i << size_log2(dt_ff)) : '0;
	assign dsel = (mode == MODE_BDISP || mode == MODE_BDISP_DEF) ? 2'h0 :
		(mode == MODE_WDISP || mode == MODE_WDISP_DEF) ? 2'h1 : 2'h2;
	assign disp = sign_widen(ext_ff, dsel);
	assign deferred = mode == MODE_BDISP_DEF || mode == MODE_WDISP_DEF ||
		mode == MODE_LDISP_DEF || (mode == MODE_AUTOINC_DEF && rn != REG_PC);
	// Fault decode; the base of an index also faults as literal, index, register or immediate mode
	always_comb begin
		ill_now = 1'b0;
		if (is_lit && acc_ff inside {AC_ADDR, AC_MODIFY, AC_WRITE}) begin
			ill_now = 1'b1;
		end
		if (is_idx && (base_ff[7:6] == LIT_TAG || base_ff[7:4] == MODE_INDEX ||
			base_ff[7:4] == MODE_REG ||
			(base_ff[7:4] == MODE_AUTOINC && base_ff[3:0] == REG_PC))) begin
			ill_now = 1'b1;
		end
		if (mode == MODE_REG && acc_ff == AC_ADDR) begin
			ill_now = 1'b1;
		end
	end
	assign rsv_now = is_idx && spec_ff[3:0] == REG_PC && !ill_now;
	// Base operand location before indexing
	always_comb begin
		ea = rb;
		case (mode)
			MODE_AUTODEC: ea = rb - size;
			MODE_AUTOINC: ea = (rn == REG_PC) ? pc_ff - size : rb;
			MODE_AUTOINC_DEF: ea = (rn == REG_PC) ? ext_ff : rb;
			MODE_BDISP, MODE_BDISP_DEF, MODE_WDISP, MODE_WDISP_DEF,
			MODE_LDISP, MODE_LDISP_DEF: ea = rb + disp;
			default: ea = rb;
		endcase
	end
	always_comb begin
		nxt_state = state_ff;
		nxt_spec = spec_ff;
		nxt_base = base_ff;
		nxt_ext = ext_ff;
		nxt_pc = pc_ff;
		nxt_acc = acc_ff;
		nxt_dt = dt_ff;
		nxt_br = br_ff;
		nxt_brw = brw_ff;
		nxt_idx_off = idx_off_ff;
		nxt_addr = addr_ff;
		nxt_maddr = maddr_ff;
		nxt_litv = litv_ff;
		nxt_lit = lit_ff;
		nxt_ill = ill_ff;
		nxt_rsv = rsv_ff;
		nxt_done = 1'b0;
		nxt_wb = 1'b0;
		nxt_wbs = wbs_ff;
		nxt_wbd = wbd_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_i) begin
					nxt_spec = spec_i;
					nxt_base = base_spec_i;
					nxt_ext = ext_i;
					nxt_pc = next_pc_i;
					nxt_acc = access_i;
					nxt_dt = dtype_i;
					nxt_br = branch_i;
					nxt_brw = branch_word_i;
					nxt_state = ST_EVAL;
				end
			end
			ST_EVAL: begin
				nxt_ill = 1'b0;
				nxt_rsv = 1'b0;
				nxt_lit = 1'b0;
				nxt_litv = '0;
				nxt_state = ST_IDLE;
				nxt_done = 1'b1;
				nxt_idx_off = idx_now;
				if (br_ff) begin
					nxt_addr = pc_ff + sign_widen(ext_ff, {1'b0, brw_ff});
				end else if (ill_now || rsv_now) begin
					nxt_ill = ill_now;
					nxt_rsv = rsv_now;
				end else if (is_lit) begin
					nxt_lit = 1'b1;
					nxt_litv = lit_exp;
				end else begin
					if ((mode == MODE_AUTOINC || mode == MODE_AUTOINC_DEF ||
						mode == MODE_AUTODEC) && rn != REG_PC) begin
						nxt_wb = 1'b1;
						nxt_wbs = rn;
						nxt_wbd = (mode == MODE_AUTODEC) ? ea :
							(mode == MODE_AUTOINC) ? rb + size : rb + ADDR_STEP;
					end
					if (deferred) begin
						nxt_maddr = ea;
						nxt_done = 1'b0;
						nxt_state = ST_MEM;
					end else begin
						nxt_addr = ea + idx_now;
					end
				end
			end
			ST_MEM: begin
				if (mem_ack_i) begin
					nxt_addr = mem_data_i + idx_off_ff;
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			state_ff <= ST_IDLE;
			spec_ff <= 8'h00;
			base_ff <= 8'h00;
			ext_ff <= 32'h0000_0000;
			pc_ff <= 32'h0000_0000;
			acc_ff <= AC_READ;
			dt_ff <= DT_BYTE;
			br_ff <= 1'b0;
			brw_ff <= 1'b0;
			idx_off_ff <= 32'h0000_0000;
			addr_ff <= 32'h0000_0000;
			maddr_ff <= 32'h0000_0000;
			litv_ff <= '0;
			lit_ff <= 1'b0;
			ill_ff <= 1'b0;
			rsv_ff <= 1'b0;
			done_ff <= 1'b0;
			wb_ff <= 1'b0;
			wbs_ff <= 4'h0;
			wbd_ff <= 32'h0000_0000;
		end else begin
			state_ff <= nxt_state;
			spec_ff <= nxt_spec;
			base_ff <= nxt_base;
			ext_ff <= nxt_ext;
			pc_ff <= nxt_pc;
			acc_ff <= nxt_acc;
			dt_ff <= nxt_dt;
			br_ff <= nxt_br;
			brw_ff <= nxt_brw;
			idx_off_ff <= nxt_idx_off;
			addr_ff <= nxt_addr;
			maddr_ff <= nxt_maddr;
			litv_ff <= nxt_litv;
			lit_ff <= nxt_lit;
			ill_ff <= nxt_ill;
			rsv_ff <= nxt_rsv;
			done_ff <= nxt_done;
			wb_ff <= nxt_wb;
			wbs_ff <= nxt_wbs;
			wbd_ff <= nxt_wbd;
		end
	end
	assign mem_req_o = state_ff == ST_MEM;
	assign mem_addr_o = maddr_ff;
	assign wb_o = wb_ff;
	assign wb_sel_o = wbs_ff;
	assign wb_data_o = wbd_ff;
	assign busy_o = state_ff != ST_IDLE;
	assign done_o = done_ff;
	assign addr_o = addr_ff;
	assign literal_o = lit_ff;
	assign lit_value_o = litv_ff;
	assign illegal_fault_o = ill_ff;
	assign reserved_fault_o = rsv_ff;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_defer_issue;
		state_ff == ST_EVAL && !br_ff && !ill_now && !rsv_now && !is_lit && deferred;
	endsequence
	defer_read_a: assert property (s_defer_issue and mode != MODE_AUTOINC_DEF |=>
		mem_req_o && mem_addr_o == $past(rb + disp)) else $error("deferred read address wrong");
	pc_base_a: assert property (s_defer_issue and rn == REG_PC |=>
		mem_addr_o == $past(pc_ff + disp)) else $error("pc base not updated pc");
	lit_zero_a: assert property (done_o && literal_o && dt_ff inside {DT_BYTE,
		DT_WORD, DT_LONG, DT_QUAD, DT_OCTA} |-> lit_value_o == {122'h0, spec_ff[5:0]})
		else $error("integer literal not zero widened");
	lit_float_a: assert property (done_o && literal_o && dt_ff == DT_FFLT |->
		lit_value_o[14:7] == F_BIAS + {5'h00, spec_ff[5:3]} && lit_value_o[6:4] == spec_ff[2:0])
		else $error("float literal fields wrong");
	lit_span_a: assert property (done_o && literal_o && dt_ff == DT_FFLT |->
		lit_value_o[LIT_W-1:15] == '0 && lit_value_o[3:0] == 4'h0 && lit_value_o[14])
		else $error("float literal out of range");
	lit_fault_a: assert property (state_ff == ST_EVAL && !br_ff && is_lit &&
		acc_ff inside {AC_ADDR, AC_MODIFY, AC_WRITE} |=> done_o && illegal_fault_o && !literal_o)
		else $error("literal access fault missing");
	idx_base_a: assert property (state_ff == ST_EVAL && !br_ff && is_idx &&
		(base_ff[7:6] == LIT_TAG || base_ff[7:4] == MODE_INDEX || base_ff[7:4] == MODE_REG)
		|=> done_o && illegal_fault_o) else $error("bad index base not faulted");
	idx_pc_a: assert property (done_o && !br_ff && is_idx && spec_ff[3:0] == REG_PC &&
		!illegal_fault_o |-> reserved_fault_o) else $error("pc index not reserved");
	br_target_a: assert property (state_ff == ST_EVAL && br_ff |=> done_o &&
		addr_o == $past(pc_ff + sign_widen(ext_ff, {1'b0, brw_ff})))
		else $error("branch target wrong");
	mem_done_a: assert property (mem_req_o && mem_ack_i |=> done_o &&
		addr_o == $past(mem_data_i + idx_off_ff)) else $error("indexed deferred address wrong");
endmodule

// >>> verification/osae_mem_model.sv
// Partner model: register file and longword memory for the evaluator.
// Assumes same-cycle register reads and a memory ack lat_i cycles late.
`timescale 1ns/1ps
module osae_mem_model (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [1:0] lat_i,
	input wire logic [3:0] base_sel_i,
	input wire logic [3:0] index_sel_i,
	output logic [31:0] base_data_o,
	output logic [31:0] index_data_o,
	input wire logic mem_req_i,
	input wire logic [31:0] mem_addr_i,
	output logic mem_ack_o,
	output logic [31:0] mem_data_o
);
	logic [1:0] cnt_ff;
	logic [31:0] pat_ff;
	// Register n holds a value built from its number
	assign base_data_o = {12'h000, base_sel_i, 16'h1000};
	assign index_data_o = {12'h000, index_sel_i, 16'h1000};
	// Longword at an address is its inverse; junk between answers
	assign mem_ack_o = mem_req_i && (cnt_ff == lat_i);
	assign mem_data_o = mem_ack_o ? ~mem_addr_i : pat_ff;
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			pat_ff <= 32'h1234_5678;
		end else begin
			pat_ff <= pat_ff + 32'h9E37_79B9;
		end
		if (!rst_b_i || mem_ack_o || !mem_req_i) begin
			cnt_ff <= 2'h0;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
		end
	end
endmodule

// >>> verification/operand_specifier_address_eval_tb.sv
// Self-checking bench for the operand specifier evaluator.
// Assumes the partner model answers registers and memory reads.
`timescale 1ns/1ps
module operand_specifier_address_eval_tb;
	import osae_pkg::*;
	logic clock_i = 0, rst_b_i = 0, start_i = 0, branch_i = 0, branch_word_i = 0;
	logic [7:0] spec_i = 0, base_spec_i = 0;
	logic [31:0] ext_i = 0, next_pc_i = 0, base_data_i, index_data_i, mem_data_i;
	osae_access_t access_i = AC_READ;
	osae_dtype_t dtype_i = DT_BYTE;
	logic [3:0] base_sel_o, index_sel_o, wb_sel_o;
	logic mem_req_o, mem_ack_i, wb_o, busy_o, done_o, literal_o, illegal_fault_o, reserved_fault_o;
	logic [31:0] mem_addr_o, wb_data_o, addr_o;
	logic [LIT_W-1:0] lit_value_o;
	logic [1:0] lat = 0;
	logic [31:0] npc = 0;
	int num_errors = 0, compares = 0, cyc = 0;
	always #50 clock_i = ~clock_i;
	osae_eval dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .start_i(start_i), .branch_i(branch_i),
		.branch_word_i(branch_word_i), .spec_i(spec_i), .base_spec_i(base_spec_i), .ext_i(ext_i),
		.access_i(access_i), .dtype_i(dtype_i), .next_pc_i(next_pc_i), .base_sel_o(base_sel_o),
		.base_data_i(base_data_i), .index_sel_o(index_sel_o), .index_data_i(index_data_i),
		.mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
		.mem_data_i(mem_data_i), .wb_o(wb_o), .wb_sel_o(wb_sel_o), .wb_data_o(wb_data_o),
		.busy_o(busy_o), .done_o(done_o), .addr_o(addr_o), .literal_o(literal_o),
		.lit_value_o(lit_value_o), .illegal_fault_o(illegal_fault_o),
		.reserved_fault_o(reserved_fault_o));
	osae_mem_model partner (.clock_i(clock_i), .rst_b_i(rst_b_i), .lat_i(lat),
		.base_sel_i(base_sel_o), .index_sel_i(index_sel_o), .base_data_o(base_data_i),
		.index_data_o(index_data_i), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
		.mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i));
	function automatic logic [31:0] rf(input logic [3:0] n);
		rf = {12'h000, n, 16'h1000};
	endfunction
	task automatic summarize();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk_v(input logic [127:0] got, input logic [127:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_f(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	// One specifier, waits for its done pulse
	task automatic go(input logic [7:0] s, input logic [7:0] b, input logic [31:0] e,
			input osae_access_t a, input osae_dtype_t d, input logic br, input logic bw);
		int n;
		n = 0;
		spec_i <= s;
		base_spec_i <= b;
		ext_i <= e;
		access_i <= a;
		dtype_i <= d;
		branch_i <= br;
		branch_word_i <= bw;
		next_pc_i <= npc;
		start_i <= 1'b1;
		@(posedge clock_i);
		start_i <= 1'b0;
		@(posedge clock_i);
		chk_f(busy_o, 1'b1);
		while (done_o !== 1'b1 && n < 20) begin
			@(posedge clock_i);
			n++;
		end
		chk_f(done_o, 1'b1);
		chk_f(busy_o, 1'b0);
	endtask
	task automatic t_defer();
		go(8'hB3, 8'h00, 32'h0000_00F0, AC_READ, DT_LONG, 0, 0);
		chk_v(addr_o, 32'(~(rf(4'h3) - 32'h10)));
		lat = 2'h3;
		npc = 32'h0000_2000;
		go(8'hDF, 8'h00, 32'h0000_8000, AC_WRITE, DT_WORD, 0, 0);
		chk_v(addr_o, 32'h0000_5FFF);
	endtask
	task automatic t_lit();
		for (int d = 0; d < 5; d++) begin
			go(8'h3F, 8'h00, 32'h0, AC_READ, osae_dtype_t'(d), 0, 0);
			chk_f(literal_o, 1'b1);
			chk_v(lit_value_o, 128'h3F);
		end
		for (int v = 0; v < 64; v++) begin
			go({2'h0, 6'(v)}, 8'h00, 32'h0, AC_READ, DT_FFLT, 0, 0);
			chk_v(lit_value_o, {113'h0, 8'h80 + 8'(v / 8), 3'(v), 4'h0});
		end
		for (int a = 1; a < 4; a++) begin
			go(8'h05, 8'h00, 32'h0, osae_access_t'(a), DT_LONG, 0, 0);
			chk_f(illegal_fault_o, 1'b1);
		end
	endtask
	task automatic t_index();
		logic [7:0] bad [4] = '{8'h53, 8'h05, 8'h8F, 8'h44};
		foreach (bad[i]) begin
			go(8'h42, bad[i], 32'h0, AC_READ, DT_LONG, 0, 0);
			chk_f(illegal_fault_o, 1'b1);
		end
		// Register mode alone with address access
		go(8'h53, 8'h00, 32'h0, AC_ADDR, DT_LONG, 0, 0);
		chk_f(illegal_fault_o, 1'b1);
		// Index register differs from the stepped base
		go(8'h42, 8'h73, 32'h0, AC_READ, DT_QUAD, 0, 0);
		chk_v(addr_o, rf(4'h3) - 32'h8 + rf(4'h2) * 8);
		chk_f(wb_o, 1'b1);
		chk_v({wb_sel_o, wb_data_o}, {4'h3, rf(4'h3) - 32'h8});
		lat = 2'h2;
		go(8'h45, 8'hB3, 32'h0000_0010, AC_MODIFY, DT_OCTA, 0, 0);
		chk_v(addr_o, 32'(~(rf(4'h3) + 32'h10) + rf(4'h5) * 16));
		go(8'h4F, 8'h63, 32'h0, AC_READ, DT_LONG, 0, 0);
		chk_f(reserved_fault_o, 1'b1);
		chk_f(illegal_fault_o, 1'b0);
	endtask
	task automatic t_branch();
		npc = 32'hFFFF_FFF0;
		go(8'h00, 8'h00, 32'h1234_5620, AC_READ, DT_BYTE, 1, 0);
		chk_v(addr_o, 32'h0000_0010);
		npc = 32'h0000_4000;
		go(8'h00, 8'h00, 32'h0000_8000, AC_READ, DT_WORD, 1, 1);
		chk_v(addr_o, 32'hFFFF_C000);
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		repeat (2) @(posedge clock_i);
		rst_b_i <= 1'b1;
		@(posedge clock_i);
		t_defer();
		t_lit();
		t_index();
		t_branch();
		summarize();
	end
endmodule
